//--- hdl/clk_cond_pkg.sv
package clk_cond_pkg;

  // register addresses on the serial port (15-bit address space)
  localparam logic [14:0] ADDR_CHAN_PAGE   = 15'h0008;
  localparam logic [14:0] ADDR_DIV_RATIO   = 15'h0108;
  localparam logic [14:0] ADDR_SYSREF_CTRL = 15'h010B;
  localparam logic [14:0] ADDR_HALF_DELAY  = 15'h010C;
  localparam logic [14:0] ADDR_DELAY_CTRL  = 15'h0110;
  localparam logic [14:0] ADDR_SUPERFINE   = 15'h0111;
  localparam logic [14:0] ADDR_FINE        = 15'h0112;
  localparam logic [14:0] ADDR_STAB_A      = 15'h011C;
  localparam logic [14:0] ADDR_STAB_B      = 15'h011E;

  // serial frame: read flag, 15 address bits, 8 data bits
  localparam logic [4:0]  SPI_LAST_HDR_BIT  = 5'h0F;
  localparam logic [4:0]  SPI_FIRST_RD_SHIFT = 5'h11;
  localparam logic [4:0]  SPI_LAST_BIT      = 5'h17;
  localparam logic [4:0]  SPI_DONE_CNT      = 5'h18;

  // synchroniser lanes
  localparam int SYNC_CSB    = 0;
  localparam int SYNC_SCLK   = 1;
  localparam int SYNC_SDI    = 2;
  localparam int SYNC_SYSREF = 3;

  // divider ratio codes and the last phase count for each
  localparam logic [1:0]  DIV_BY1 = 2'h0;
  localparam logic [1:0]  DIV_BY2 = 2'h1;
  localparam logic [1:0]  DIV_BY4 = 2'h3;
  localparam logic [1:0]  LAST_BY1 = 2'h0;
  localparam logic [1:0]  LAST_BY2 = 2'h1;
  localparam logic [1:0]  LAST_BY4 = 2'h3;
  localparam logic [1:0]  HIGH_PHASES_BY4 = 2'h2;

  // field positions
  localparam int SYSREF_EN_BIT  = 0;
  localparam int SYSREF_PH_LSB  = 2;
  localparam int FINE_RES_BIT   = 2;
  localparam int ENABLE_BIT     = 0;

  // delay control modes and step limits
  localparam logic [2:0]  DLY_MODE_OFF  = 3'h0;
  localparam logic [2:0]  DLY_MODE_SF_A = 3'h2;
  localparam logic [2:0]  DLY_MODE_SF_B = 3'h6;
  localparam logic [7:0]  FINE_MAX_16   = 8'h0F;
  localparam logic [7:0]  FINE_MAX_192  = 8'hBF;
  localparam logic [7:0]  SUPERFINE_MAX = 8'h7F;
  localparam int          SUPERFINE_STEP_FS = 250;

  // reset values
  localparam logic [1:0]  CHAN_PAGE_RST = 2'h3;
  localparam logic [1:0]  DIV_RATIO_RST = 2'h0;
  localparam logic [3:0]  SYSREF_RST    = 4'h0;
  localparam logic [2:0]  DLY_CTRL_RST  = 3'h0;
  localparam logic [7:0]  DLY_VALUE_RST = 8'h00;

  // per-channel delay settings handed to the analog delay lines
  typedef struct packed {
    logic       half_cycle;
    logic       fine_on;
    logic       fine_192;
    logic [7:0] fine;
    logic       superfine_on;
    logic [7:0] superfine;
  } chan_delay_t;

  typedef enum logic [2:0] {
    SPI_IDLE = 3'b001,
    SPI_HEAD = 3'b010,
    SPI_DATA = 3'b100
  } spi_state_t;

endpackage

//--- hdl/adc_clock_conditioner.sv
// Function
// R1 - divide the input clock by one, two or four per the ratio register
// R2 - host loads the divide ratio before applying the clock
// R3 - valid SYSREF resets the divider to a programmed phase state
// R4 - half input cycle phase delay, enabled separately per channel
// R5 - writing the half-period register does not disturb the output link
// R6 - three-bit control selects fine or fine plus superfine; superfine only at 2 or 6
// R7 - fine delay offers sixteen-step and 192-step resolutions
// R8 - eight-bit fine value sets edge delay across up to 192 steps
// R9 - eight-bit unsigned superfine value gives 128 quarter-picosecond steps
// R10 - fine and superfine values are held separately for both channels
// R11 - delay changes take effect at once after the serial write
// R12 - enabling fine delay in the control register resets the datapath
// R13 - changing fine or superfine values causes no datapath reset
// R14 - lower-rate grade leaves reset with duty-cycle stabiliser off
// R15 - higher-rate grade leaves reset with duty-cycle stabiliser on
// R16 - host turns on both stabiliser stages when no faster clock exists
// R17 - divided clock to the converter has fifty percent duty cycle; DIV_CLK is held high at divide by one
// R18 - host applies matching settings to digital and analog delay circuits
// R19 - after realignment counting resumes from the programmed state next edge
module adc_clock_conditioner
  import clk_cond_pkg::*;
#(
  parameter bit HIGH_RATE_GRADE = 1'b0
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // alignment pulse from the clock source
  input  wire logic        SYSREF,
  // serial control port
  input  wire logic        SPI_CSB_N,
  input  wire logic        SPI_SCLK,
  input  wire logic        SPI_SDI,
  output logic             SPI_SDO,
  output logic             SPI_SDO_OE_N,
  // divided sample clock
  output logic             DIV_CLK,
  output logic             SAMPLE_EN,
  output logic [1:0]       DIV_PHASE,
  // per-channel delay controls
  output chan_delay_t      CHAN_A_DELAY,
  output chan_delay_t      CHAN_B_DELAY,
  output logic             DATAPATH_RESET,
  // duty-cycle stabiliser stages
  output logic             DUTY_CYCLE_STABILISER_STAGE_ONE_EN,
  output logic             DUTY_CYCLE_STABILISER_STAGE_TWO_EN
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // last phase count of the divider for a ratio code
  function automatic logic [1:0] div_last(input logic [1:0] code);
    if (code == DIV_BY4) begin
      div_last = LAST_BY4;
    end else if (code == DIV_BY2) begin
      div_last = LAST_BY2;
    end else begin
      div_last = LAST_BY1;
    end
  endfunction

  // divided clock level: high for the first half of a two- or four-cycle period, always high at ratio one
  function automatic logic div_level(input logic [1:0] code, input logic [1:0] cnt);
    if (code == DIV_BY4) begin
      div_level = (cnt < HIGH_PHASES_BY4);
    end else if (code == DIV_BY2) begin
      div_level = (cnt == LAST_BY1);
    end else begin
      div_level = 1'b1;
    end
  endfunction

  // effective delay settings for one channel
  function automatic chan_delay_t pack_delay(input logic       half,
                                             input logic [2:0] mode,
                                             input logic [7:0] fine,
                                             input logic [7:0] sfine);
    chan_delay_t d;
    logic [7:0]  lim;
    d            = '0;
    lim          = mode[FINE_RES_BIT] ? FINE_MAX_192 : FINE_MAX_16;      // R7
    d.half_cycle = half;                                                 // R4
    d.fine_on    = (mode != DLY_MODE_OFF);
    d.fine_192   = mode[FINE_RES_BIT];                                   // R7
    d.fine       = d.fine_on ? ((fine > lim) ? lim : fine) : DLY_VALUE_RST; // R8
    d.superfine_on = (mode == DLY_MODE_SF_A) || (mode == DLY_MODE_SF_B); // R6
    d.superfine  = d.superfine_on ? ((sfine > SUPERFINE_MAX) ? SUPERFINE_MAX : sfine)
                                  : DLY_VALUE_RST;                       // R9
    pack_delay   = d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;
  logic [3:0] filt_ff;
  logic [3:0] filt_q_ff;
  logic [3:0] nxt_filt;

  // a lane only moves once the second and third stages agree
  assign nxt_filt = (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff ^ sync3_ff));

  // three stages; the first is read by the second only
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_ff  <= 4'h3;  // csb and sclk idle high: no false edge at release
      sync2_ff  <= 4'h3;
      sync3_ff  <= 4'h3;
      filt_ff   <= 4'h3;
      filt_q_ff <= 4'h3;
    end else begin
      sync1_ff  <= {SYSREF, SPI_SDI, SPI_SCLK, SPI_CSB_N};
      sync2_ff  <= sync1_ff;
      sync3_ff  <= sync2_ff;
      filt_ff   <= nxt_filt;
      filt_q_ff <= filt_ff;
    end
  end

  logic cs_active;
  logic sclk_rise;
  logic sclk_fall;
  logic sysref_rise;
  logic sdi_bit;

  assign cs_active   = ~filt_ff[SYNC_CSB];
  assign sclk_rise   = filt_ff[SYNC_SCLK] & ~filt_q_ff[SYNC_SCLK];
  assign sclk_fall   = ~filt_ff[SYNC_SCLK] & filt_q_ff[SYNC_SCLK];
  assign sysref_rise = filt_ff[SYNC_SYSREF] & ~filt_q_ff[SYNC_SYSREF];
  assign sdi_bit     = filt_ff[SYNC_SDI];

  ////////////////////////////////////////////////////////////////////////////
  // serial port

  spi_state_t  spi_state_ff;
  logic [4:0]  bit_cnt_ff;
  logic [14:0] shift_ff;
  logic        rd_mode_ff;
  logic [14:0] addr_ff;
  logic [7:0]  rd_shift_ff;
  logic [7:0]  rd_value;
  logic        wr_stb;
  logic [7:0]  wr_data;
  logic [14:0] hdr_addr;

  assign hdr_addr = {shift_ff[13:0], sdi_bit};
  assign wr_data  = {shift_ff[6:0], sdi_bit};
  // write commits on the last data bit; a frame cut short writes nothing
  assign wr_stb   = (spi_state_ff == SPI_DATA) && cs_active && sclk_rise &&
                    (bit_cnt_ff == SPI_LAST_BIT) && !rd_mode_ff;

  // frame sequencing; deasserting chip select always returns to idle
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      spi_state_ff <= SPI_IDLE;
      bit_cnt_ff   <= 5'h00;
      rd_mode_ff   <= 1'b0;
      addr_ff      <= 15'h0000;
    end else begin
      case (spi_state_ff)
        SPI_IDLE: begin
          bit_cnt_ff <= 5'h00;
          if (cs_active) begin
            spi_state_ff <= SPI_HEAD;
          end
        end
        SPI_HEAD: begin
          if (!cs_active) begin
            spi_state_ff <= SPI_IDLE;
          end else if (sclk_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == SPI_LAST_HDR_BIT) begin
              spi_state_ff <= SPI_DATA;
              rd_mode_ff   <= shift_ff[14];
              addr_ff      <= hdr_addr;
            end
          end
        end
        SPI_DATA: begin
          if (!cs_active) begin
            spi_state_ff <= SPI_IDLE;
          end else if (sclk_rise && bit_cnt_ff != SPI_DONE_CNT) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
          end
        end
        default: begin
          spi_state_ff <= SPI_IDLE;
        end
      endcase
    end
  end

  // input shifter
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      shift_ff <= 15'h0000;
    end else if (spi_state_ff == SPI_IDLE) begin
      shift_ff <= 15'h0000;
    end else if (sclk_rise) begin
      shift_ff <= {shift_ff[13:0], sdi_bit};
    end
  end

  // read shifter: loaded at the end of the header, advanced on falling edges
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rd_shift_ff <= 8'h00;
    end else if (spi_state_ff == SPI_HEAD && sclk_rise && bit_cnt_ff == SPI_LAST_HDR_BIT) begin
      rd_shift_ff <= rd_value;
    end else if (spi_state_ff == SPI_DATA && sclk_fall && bit_cnt_ff >= SPI_FIRST_RD_SHIFT) begin
      rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
    end
  end

  assign SPI_SDO      = rd_shift_ff[7];
  assign SPI_SDO_OE_N = !(spi_state_ff == SPI_DATA && rd_mode_ff && cs_active);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [1:0] page_ff;
  logic [1:0] div_ratio_ff;
  logic [3:0] sysref_ctrl_ff;
  logic       half_ff   [2];
  logic [2:0] dly_ctrl_ff [2];
  logic [7:0] sfine_ff  [2];
  logic [7:0] fine_ff   [2];
  logic       stab_a_ff;
  logic       stab_b_ff;
  logic       rd_ch;
  logic [1:0] dp_trig;

  // reads show the lowest selected channel
  assign rd_ch = ~page_ff[0];

  // global settings
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      page_ff        <= CHAN_PAGE_RST;
      div_ratio_ff   <= DIV_RATIO_RST;
      sysref_ctrl_ff <= SYSREF_RST;
    end else if (wr_stb) begin
      if (addr_ff == ADDR_CHAN_PAGE) begin
        page_ff <= wr_data[1:0];
      end else if (addr_ff == ADDR_DIV_RATIO) begin
        div_ratio_ff <= wr_data[1:0];                                    // R1
      end else if (addr_ff == ADDR_SYSREF_CTRL) begin
        sysref_ctrl_ff <= wr_data[3:0];                                  // R3
      end
    end
  end

  // stabiliser stages come out of reset according to the speed grade
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      stab_a_ff <= HIGH_RATE_GRADE;                                      // R14
      stab_b_ff <= HIGH_RATE_GRADE;                                      // R15
    end else if (wr_stb) begin
      if (addr_ff == ADDR_STAB_A) begin
        stab_a_ff <= wr_data[ENABLE_BIT];
      end else if (addr_ff == ADDR_STAB_B) begin
        stab_b_ff <= wr_data[ENABLE_BIT];
      end
    end
  end

  // paged per-channel delay settings
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 2; i++) begin
        half_ff[i]     <= 1'b0;
        dly_ctrl_ff[i] <= DLY_CTRL_RST;
        sfine_ff[i]    <= DLY_VALUE_RST;
        fine_ff[i]     <= DLY_VALUE_RST;
      end
    end else if (wr_stb) begin
      for (int i = 0; i < 2; i++) begin
        if (page_ff[i]) begin
          if (addr_ff == ADDR_HALF_DELAY) begin
            half_ff[i] <= wr_data[ENABLE_BIT];                           // R4
          end else if (addr_ff == ADDR_DELAY_CTRL) begin
            dly_ctrl_ff[i] <= wr_data[2:0];                              // R6
          end else if (addr_ff == ADDR_SUPERFINE) begin
            sfine_ff[i] <= wr_data;                                      // R10
          end else if (addr_ff == ADDR_FINE) begin
            fine_ff[i] <= wr_data;                                       // R10
          end
        end
      end
    end
  end

  // read mux; unmapped addresses and reserved bits read as zero
  always_comb begin
    rd_value = 8'h00;
    if (hdr_addr == ADDR_CHAN_PAGE) begin
      rd_value = {6'h00, page_ff};
    end else if (hdr_addr == ADDR_DIV_RATIO) begin
      rd_value = {6'h00, div_ratio_ff};
    end else if (hdr_addr == ADDR_SYSREF_CTRL) begin
      rd_value = {4'h0, sysref_ctrl_ff};
    end else if (hdr_addr == ADDR_HALF_DELAY) begin
      rd_value = {7'h00, half_ff[rd_ch]};
    end else if (hdr_addr == ADDR_DELAY_CTRL) begin
      rd_value = {5'h00, dly_ctrl_ff[rd_ch]};
    end else if (hdr_addr == ADDR_SUPERFINE) begin
      rd_value = sfine_ff[rd_ch];
    end else if (hdr_addr == ADDR_FINE) begin
      rd_value = fine_ff[rd_ch];
    end else if (hdr_addr == ADDR_STAB_A) begin
      rd_value = {7'h00, stab_a_ff};
    end else if (hdr_addr == ADDR_STAB_B) begin
      rd_value = {7'h00, stab_b_ff};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath reset

  // only a change from off to on in the control register resets the path;
  // value writes and half-period writes never reach this term
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      dp_trig[i] = wr_stb && page_ff[i] && (addr_ff == ADDR_DELAY_CTRL) &&
                   (dly_ctrl_ff[i] == DLY_MODE_OFF) && (wr_data[2:0] != DLY_MODE_OFF); // R12
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      DATAPATH_RESET <= 1'b0;
    end else begin
      DATAPATH_RESET <= |dp_trig;                                        // R13 R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay outputs

  // settings go straight to the delay lines, no commit step is needed
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      CHAN_A_DELAY <= '0;
      CHAN_B_DELAY <= '0;
    end else begin
      CHAN_A_DELAY <= pack_delay(half_ff[0], dly_ctrl_ff[0], fine_ff[0], sfine_ff[0]); // R11
      CHAN_B_DELAY <= pack_delay(half_ff[1], dly_ctrl_ff[1], fine_ff[1], sfine_ff[1]); // R11
    end
  end

  assign DUTY_CYCLE_STABILISER_STAGE_ONE_EN = stab_a_ff;
  assign DUTY_CYCLE_STABILISER_STAGE_TWO_EN = stab_b_ff;

  ////////////////////////////////////////////////////////////////////////////
  // divider

  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic [1:0] last_cnt;
  logic       sysref_valid;

  assign last_cnt     = div_last(div_ratio_ff);
  assign sysref_valid = sysref_rise && sysref_ctrl_ff[SYSREF_EN_BIT];

  // a ratio lowered mid-period wraps at once instead of running past its end
  always_comb begin
    if (sysref_valid) begin
      nxt_cnt = sysref_ctrl_ff[SYSREF_PH_LSB +: 2] & last_cnt;          // R3
    end else if (cnt_ff >= last_cnt) begin
      nxt_cnt = 2'h0;                                                    // R1
    end else begin
      nxt_cnt = cnt_ff + 2'h1;                                           // R19
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_ff    <= 2'h0;
      DIV_CLK   <= 1'b1;
      SAMPLE_EN <= 1'b0;
      DIV_PHASE <= 2'h0;
    end else begin
      cnt_ff    <= nxt_cnt;
      DIV_CLK   <= div_level(div_ratio_ff, nxt_cnt);                     // R17
      SAMPLE_EN <= (nxt_cnt == 2'h0);                                    // R1
      DIV_PHASE <= nxt_cnt;
    end
  end

endmodule

//--- testbench/clk_cond_asserts.sv
module clk_cond_asserts
  import clk_cond_pkg::*;
#(
  parameter bit HIGH_RATE_GRADE = 1'b0
) (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RST_N,
  // pins watched
  input wire logic        SYSREF,
  input wire logic        SPI_CSB_N,
  input wire logic        DIV_CLK,
  input wire logic        SAMPLE_EN,
  input wire logic [1:0]  DIV_PHASE,
  input wire chan_delay_t CHAN_A_DELAY,
  input wire chan_delay_t CHAN_B_DELAY,
  input wire logic        DATAPATH_RESET,
  input wire logic        DUTY_CYCLE_STABILISER_STAGE_ONE_EN,
  input wire logic        DUTY_CYCLE_STABILISER_STAGE_TWO_EN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] sysref_age_ff;
  logic [5:0] csb_age_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // ages saturate, so a long quiet pin reads as far in the past
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sysref_age_ff <= 6'h3F;
    end else begin
      sysref_age_ff <= SYSREF ? 6'h00 : sysref_age_ff + 6'(sysref_age_ff != 6'h3F);
    end
  end

  // serial activity age: register changes must trace back to a frame
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      csb_age_ff <= 6'h3F;
    end else begin
      csb_age_ff <= !SPI_CSB_N ? 6'h00 : csb_age_ff + 6'(csb_age_ff != 6'h3F);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // phases 2, 3 and 0 follow one another at divide by four, the only ratio that reaches phase 2
  sequence s_wrap_by4;
    DIV_PHASE == 2'h2 ##1 DIV_PHASE == 2'h3 ##1 DIV_PHASE == 2'h0;
  endsequence

  property p_phase_wrap;
    (sysref_age_ff > 6'h0B) && (csb_age_ff > 6'h1F) && DIV_PHASE == 2'h2 |-> s_wrap_by4;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("divider phase skipped");

  property p_sample_phase;
    $past(RST_N) |-> SAMPLE_EN == (DIV_PHASE == 2'h0);
  endproperty
  a_sample_phase: assert property (p_sample_phase) else $error("sample enable off phase");

  property p_clk_high;
    DIV_PHASE == 2'h0 |-> DIV_CLK;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("divided clock low at phase 0");

  property p_clk_low;
    DIV_PHASE[1] |-> !DIV_CLK;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("divided clock high late");

  property p_dp_pulse;
    DATAPATH_RESET |=> !DATAPATH_RESET;
  endproperty
  a_dp_pulse: assert property (p_dp_pulse) else $error("datapath reset too long");

  property p_dp_cause;
    DATAPATH_RESET |-> csb_age_ff < 6'h10;
  endproperty
  a_dp_cause: assert property (p_dp_cause) else $error("datapath reset unprompted");

  property p_stab_reset;
    !$past(RST_N) |-> DUTY_CYCLE_STABILISER_STAGE_ONE_EN == HIGH_RATE_GRADE
      && DUTY_CYCLE_STABILISER_STAGE_TWO_EN == HIGH_RATE_GRADE;
  endproperty
  a_stab_reset: assert property (p_stab_reset) else $error("stabiliser reset state");

  property p_delay_cause;
    $changed(CHAN_A_DELAY) || $changed(CHAN_B_DELAY) |-> csb_age_ff < 6'h10;
  endproperty
  a_delay_cause: assert property (p_delay_cause) else $error("delay moved unprompted");

  property p_superfine;
    CHAN_A_DELAY.superfine_on |-> CHAN_A_DELAY.fine_on && CHAN_A_DELAY.superfine <= SUPERFINE_MAX;
  endproperty
  a_superfine: assert property (p_superfine) else $error("superfine out of range");

  property p_fine_clamp;
    CHAN_A_DELAY.fine <= (CHAN_A_DELAY.fine_192 ? FINE_MAX_192 : FINE_MAX_16);
  endproperty
  a_fine_clamp: assert property (p_fine_clamp) else $error("fine delay out of range");
endmodule

bind adc_clock_conditioner clk_cond_asserts #(.HIGH_RATE_GRADE(HIGH_RATE_GRADE)) i_clk_cond_asserts (
  .CLOCK, .RST_N, .SYSREF, .SPI_CSB_N, .DIV_CLK, .SAMPLE_EN, .DIV_PHASE, .CHAN_A_DELAY,
  .CHAN_B_DELAY, .DATAPATH_RESET, .DUTY_CYCLE_STABILISER_STAGE_ONE_EN,
  .DUTY_CYCLE_STABILISER_STAGE_TWO_EN
);

//--- testbench/sysref_source.sv
module sysref_source (
  // sample clock
  input  wire logic       clock,
  // launch request and pulse length
  input  wire logic       fire,
  input  wire logic [3:0] hold_cycles,
  // alignment pulse toward the converter
  output logic            sysref
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;

  // pulse held several cycles so the pin filter on the far side sees it
  initial sysref = 1'b0;
  always @(negedge clock) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
      sysref <= (cnt > 1);
    end else if (fire) begin
      cnt <= int'(hold_cycles);
      sysref <= 1'b1;
    end
  end
endmodule

//--- testbench/adc_sample_clock_divider_delay_test.sv
module adc_sample_clock_divider_delay_test
  import clk_cond_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_n, csb_n, sclk, sdi, fire, sysref, sdo, sdo_oe_n;
  logic        div_clk, sample_en, datapath_reset, stab_one, stab_two;
  logic [1:0]  div_phase;
  chan_delay_t chan_a, chan_b;
  int          num_errors, num_checks, dp_count, rd_bits, k, ns, nh;
  logic [7:0]  rd_queue[$];
  logic [7:0]  rd_shift, lfsr_ff;
  logic [1:0]  base, codes[4] = '{DIV_BY2, DIV_BY4, DIV_BY1, 2'h2};
  int          periods[4] = '{2, 4, 1, 1};

  adc_clock_conditioner #(.HIGH_RATE_GRADE(1'b0)) i_adc_clock_conditioner (
    .CLOCK(clock), .RST_N(rst_n), .SYSREF(sysref), .SPI_CSB_N(csb_n), .SPI_SCLK(sclk),
    .SPI_SDI(sdi), .SPI_SDO(sdo), .SPI_SDO_OE_N(sdo_oe_n), .DIV_CLK(div_clk),
    .SAMPLE_EN(sample_en), .DIV_PHASE(div_phase), .CHAN_A_DELAY(chan_a), .CHAN_B_DELAY(chan_b),
    .DATAPATH_RESET(datapath_reset), .DUTY_CYCLE_STABILISER_STAGE_ONE_EN(stab_one),
    .DUTY_CYCLE_STABILISER_STAGE_TWO_EN(stab_two));
  sysref_source i_sysref_source (.clock(clock), .fire(fire), .hold_cycles(4'h8), .sysref(sysref));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic compare(input logic [19:0] seen, input logic [19:0] want, input string what);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // outputs expected from a mode and the stored values, clamped to the step range
  function automatic chan_delay_t expect_delay(input logic [2:0] m, input logic [7:0] f,
                                               input logic [7:0] s);
    logic [7:0] fmax;
    logic       sf;
    fmax = m[2] ? FINE_MAX_192 : FINE_MAX_16;
    sf = (m == DLY_MODE_SF_A) || (m == DLY_MODE_SF_B);
    return chan_delay_t'({1'b0, m != DLY_MODE_OFF, m[2], (m == DLY_MODE_OFF) ? 8'h00 :
      (f > fmax ? fmax : f), sf, sf ? (s > SUPERFINE_MAX ? SUPERFINE_MAX : s) : 8'h00});
  endfunction

  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask

  // one whole frame; slow serial clock gives the pin synchronisers room
  task automatic spi(input logic rd, input logic [14:0] addr, input logic [7:0] data);
    logic [23:0] frame;
    frame = {rd, addr, data};
    csb_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = frame[i];
      ticks(8);
      sclk = 1'b1;
      ticks(8);
    end
    csb_n = 1'b1;
    ticks(12);
  endtask

  task automatic rd(input logic [14:0] addr, input logic [7:0] want);
    rd_queue.push_back(want);
    spi(1'b1, addr, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // read watcher: gathers the answer bits and scores them against the oldest note
  always @(negedge csb_n) rd_bits = 0;
  always @(posedge sclk) begin
    if (!csb_n && sdo_oe_n === 1'b0) begin
      rd_shift = {rd_shift[6:0], sdo};
      rd_bits++;
      if (rd_bits == 8 && rd_queue.size() == 0) compare(20'h1, 20'h0, "unexpected read");
      else if (rd_bits == 8) compare(20'(rd_shift), 20'(rd_queue.pop_front()), "read");
    end
  end

  always @(posedge clock) if (datapath_reset === 1'b1) dp_count++;

  // hang guard: the run is far shorter than this
  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    $display("BAD at %0t: run limit reached", $time);
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, sclk, sdi, fire} = 4'b0100;
    {csb_n, num_errors, num_checks, dp_count, rd_bits, lfsr_ff} = {1'b1, 128'h0, 8'h41};
    ticks(4);
    rst_n = 1'b1;
    ticks(8);
    compare(20'({stab_one, stab_two}), 20'h0, "stabiliser reset");
    rd(ADDR_STAB_A, 8'h00);
    spi(1'b0, ADDR_STAB_A, 8'h01);
    spi(1'b0, ADDR_STAB_B, 8'h01);
    compare(20'({stab_one, stab_two}), 20'h3, "stabiliser on");
    $display("test stabiliser done");
    // every ratio code; the ratio is set before sampling is relied upon
    for (k = 0; k < 4; k++) begin
      spi(1'b0, ADDR_DIV_RATIO, {6'h00, codes[k]});
      {ns, nh} = 64'h0;
      repeat (8) begin
        ticks(1);
        ns += int'(sample_en);
        nh += int'(div_clk);
      end
      compare(20'(ns), 20'(8 / periods[k]), "sample rate");
      compare(20'(nh), (periods[k] == 1) ? 20'h8 : 20'h4, "duty");
    end
    $display("test divider done");
    // realign to each programmed phase from a random launch point
    spi(1'b0, ADDR_DIV_RATIO, {6'h00, DIV_BY4});
    for (k = 0; k < 4; k++) begin
      spi(1'b0, ADDR_SYSREF_CTRL, {4'h0, 2'(k), 2'b01});
      lfsr_ff = lfsr(lfsr_ff);
      ticks(int'(lfsr_ff[2:0]));
      fire <= 1'b1;
      ticks(1);
      fire <= 1'b0;
      ticks(16);
      if (k == 0) base = div_phase;
      else compare(20'(div_phase), 20'(2'(base + 2'(k))), "realign");
    end
    $display("test realign done");
    // delay modes on channel A only, stored values above the clamp limits
    spi(1'b0, ADDR_CHAN_PAGE, 8'h01);
    spi(1'b0, ADDR_FINE, 8'hC8);
    spi(1'b0, ADDR_SUPERFINE, 8'h90);
    compare(chan_a, 20'h0, "delay while off");
    for (k = 0; k < 8; k++) begin
      spi(1'b0, ADDR_DELAY_CTRL, 8'(k));
      compare(chan_a, expect_delay(3'(k), 8'hC8, 8'h90), "delay mode");
      compare(20'(dp_count), (k == 0) ? 20'h0 : 20'h1, "datapath reset");
    end
    spi(1'b0, ADDR_FINE, 8'h05);
    compare(chan_a, expect_delay(3'h7, 8'h05, 8'h90), "fine update");
    compare(chan_b, 20'h0, "other channel");
    spi(1'b0, ADDR_CHAN_PAGE, 8'h02);
    spi(1'b0, ADDR_HALF_DELAY, 8'h01);
    compare(chan_b, 20'h80000, "half cycle");
    compare(20'(chan_a.half_cycle), 20'h0, "half cycle other");
    compare(20'(dp_count), 20'h1, "no reset on update");
    $display("test delay done");
    rd(ADDR_FINE, 8'h00);
    spi(1'b0, ADDR_CHAN_PAGE, 8'h03);
    rd(ADDR_FINE, 8'h05);
    rd(ADDR_SUPERFINE, 8'h90);
    rd(15'h0200, 8'h00);
    rd(ADDR_DIV_RATIO, {6'h00, DIV_BY4});
    compare(20'(rd_queue.size()), 20'h0, "reads answered");
    $display("test readback done");
    end_sim();
  end
endmodule
